// *** rtl/epd_pkg.sv ***
// Purpose: Shared constants and types for the exception priority unit
// Assumes: 32-bit addresses and segment limit, 16-bit table limit, 8-byte vector table entries
// Notes:   Category codes double as priority order, lowest code wins
package epd_pkg;

  typedef enum logic [2:0] {
    EPD_CAT_NONE  = 3'b000,
    EPD_CAT_TRAP  = 3'b001,
    EPD_CAT_EXT   = 3'b010,
    EPD_CAT_FETCH = 3'b011,
    EPD_CAT_DEC   = 3'b100,
    EPD_CAT_EXEC  = 3'b101
  } epd_cat_e;

  typedef enum logic [1:0] {
    EPD_ST_RUN   = 2'b00,
    EPD_ST_DFLT  = 2'b01,
    EPD_ST_SHUT  = 2'b10
  } epd_state_e;

  localparam logic [7:0]  EPD_VEC_NMI   = 8'h02;
  localparam logic [7:0]  EPD_VEC_DBL   = 8'h08;
  localparam logic [7:0]  EPD_VEC_PROT  = 8'h0D;
  localparam int          EPD_ENTRY_SH  = 3;
  localparam logic [2:0]  EPD_ENTRY_LST = 3'h7;
  localparam logic [15:0] EPD_VT_LIM_RST   = 16'h03FF;
  localparam logic [31:0] EPD_TSEG_LIM_RST = 32'h0000_0067;
  localparam logic [31:0] EPD_IP_RST       = 32'h0000_0000;

endpackage

// *** rtl/epd_check_if.sv ***
// Purpose: Carries one vector lookup request and its verdict
// Assumes: Single clock domain
// Notes:   Combinational check, no handshake needed
`timescale 1ns/1ps
`default_nettype none
interface epd_check_if;
  logic [7:0]  vector;
  logic [15:0] vt_limit;
  logic        beyond;
  modport core (output vector, output vt_limit, input beyond);
  modport chk  (input vector, input vt_limit, output beyond);
endinterface
`default_nettype wire

// *** rtl/epd_vec_check.sv ***
// Purpose: Tests whether a vector entry lies past the table limit
// Assumes: Entry is eight bytes; last byte must be within limit
// Notes:   Pure combinational; the core muxes in the vector to test
`timescale 1ns/1ps
`default_nettype none
module epd_vec_check (
  epd_check_if.chk chk
);
  logic [10:0] last_byte;

  always_comb begin
    last_byte = {chk.vector, epd_pkg::EPD_ENTRY_LST};
    // Inclusive limit: the entry's last byte must not pass it
    chk.beyond = {5'h00, last_byte} > chk.vt_limit;
  end
endmodule
`default_nettype wire

// *** rtl/epd_core.sv ***
// Purpose: Arbitrates pending events and checks vector and I/O bounds
// Assumes: Pipeline presents events for one boundary at a time
// Notes:   Events are judged only on cycles with boundary high, I/O lookups on every cycle in the run state
`timescale 1ns/1ps
`default_nettype none
module epd_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Pipeline events
  input  wire logic        boundary,
  input  wire logic        trap_req,
  input  wire logic [7:0]  trap_vec,
  input  wire logic        fetch_flt,
  input  wire logic [7:0]  fetch_vec,
  input  wire logic        dec_flt,
  input  wire logic [7:0]  dec_vec,
  input  wire logic        exec_flt,
  input  wire logic [7:0]  exec_vec,
  input  wire logic [31:0] ip_boundary,
  input  wire logic        int_return_done,
  // External interrupt sources
  input  wire logic        nmi_req,
  input  wire logic        intr_req,
  input  wire logic        intr_enable,
  input  wire logic [7:0]  intr_vec,
  // System state from software
  input  wire logic        load_vector_table_descriptor,
  input  wire logic [15:0] vt_limit_in,
  input  wire logic        virtual_mode_extensions_flag,
  input  wire logic        v86_mode,
  input  wire logic [255:0] redir_bitmap,
  input  wire logic        soft_int,
  input  wire logic [7:0]  soft_vec,
  // I/O permission lookup
  input  wire logic        io_req,
  input  wire logic [31:0] io_map_base,
  input  wire logic [15:0] io_port,
  input  wire logic [31:0] tseg_limit,
  // Delivery
  output logic             deliver,
  output logic [7:0]       deliver_vec,
  output logic [2:0]       deliver_cat,
  output logic [31:0]      saved_ip,
  output logic             redirect_v86,
  output logic             io_gp,
  output logic             nmi_blocked,
  output logic             shutdown
);
  // Registered state and outputs
  epd_pkg::epd_state_e state_q;
  epd_pkg::epd_state_e state_d;
  logic [15:0]         vt_limit_q;
  logic [15:0]         vt_limit_d;
  logic                nmi_blk_q;
  logic                nmi_blk_d;
  logic                deliver_q;
  logic                deliver_d;
  logic [7:0]          deliver_vec_q;
  logic [7:0]          deliver_vec_d;
  epd_pkg::epd_cat_e   deliver_cat_q;
  epd_pkg::epd_cat_e   deliver_cat_d;
  logic [31:0]         saved_ip_q;
  logic [31:0]         saved_ip_d;
  logic                redirect_q;
  logic                redirect_d;
  logic                io_gp_q;
  logic                io_gp_d;
  logic                shutdown_q;
  logic                shutdown_d;

  // Arbitration results and I/O end address
  logic                ext_nmi;
  logic                ext_intr;
  logic                take_nmi;
  logic                soft_redir;
  logic [7:0]          win_vec;
  epd_pkg::epd_cat_e   win_cat;
  logic [32:0]         io_end;

  // Vector table bound check
  epd_check_if vchk ();

  epd_vec_check u_vec (
    .chk (vchk)
  );

  // The double fault state reuses the one checker
  assign vchk.vector   = (state_q == epd_pkg::EPD_ST_DFLT) ?
                         epd_pkg::EPD_VEC_DBL : win_vec;
  assign vchk.vt_limit = vt_limit_q;

  // Ranking of pending events
  always_comb begin
    ext_nmi    = nmi_req && !nmi_blk_q;
    ext_intr   = intr_req && intr_enable;
    soft_redir = soft_int && v86_mode &&
                 virtual_mode_extensions_flag &&
                 !redir_bitmap[soft_vec];
    win_vec    = 8'h00;
    win_cat    = epd_pkg::EPD_CAT_NONE;
    take_nmi   = 1'b0;
    if (trap_req) begin
      win_vec = trap_vec;
      win_cat = epd_pkg::EPD_CAT_TRAP;
    end else if (ext_nmi) begin
      win_vec  = epd_pkg::EPD_VEC_NMI;
      win_cat  = epd_pkg::EPD_CAT_EXT;
      take_nmi = 1'b1;
    end else if (ext_intr) begin
      win_vec = intr_vec;
      win_cat = epd_pkg::EPD_CAT_EXT;
    end else if (fetch_flt) begin
      win_vec = fetch_vec;
      win_cat = epd_pkg::EPD_CAT_FETCH;
    end else if (dec_flt) begin
      win_vec = dec_vec;
      win_cat = epd_pkg::EPD_CAT_DEC;
    end else if (exec_flt) begin
      win_vec = exec_vec;
      win_cat = epd_pkg::EPD_CAT_EXEC;
    end else if (soft_int && !soft_redir) begin
      win_vec = soft_vec;
      win_cat = epd_pkg::EPD_CAT_EXEC;
    end
  end

  // Next values
  always_comb begin
    state_d       = state_q;
    vt_limit_d    = vt_limit_q;
    nmi_blk_d     = nmi_blk_q;
    deliver_d     = 1'b0;
    deliver_vec_d = deliver_vec_q;
    deliver_cat_d = deliver_cat_q;
    saved_ip_d    = saved_ip_q;
    redirect_d    = 1'b0;
    io_gp_d       = 1'b0;
    shutdown_d    = shutdown_q;
    // No wrap: a 33-bit sum keeps the carry
    io_end        = {1'b0, io_map_base} + {17'h00000, io_port};
    if (load_vector_table_descriptor) begin
      vt_limit_d = vt_limit_in;
    end
    if (int_return_done) begin
      nmi_blk_d = 1'b0;
    end
    case (state_q)
      epd_pkg::EPD_ST_RUN: begin
        io_gp_d = io_req && (io_end > {1'b0, tseg_limit});
        if (boundary && win_cat != epd_pkg::EPD_CAT_NONE) begin
          saved_ip_d    = ip_boundary;
          deliver_cat_d = win_cat;
          // Recognition masks NMI even if its entry is bad
          if (take_nmi) begin
            nmi_blk_d = 1'b1;
          end
          if (vchk.beyond) begin
            state_d = epd_pkg::EPD_ST_DFLT;
          end else begin
            deliver_d     = 1'b1;
            deliver_vec_d = win_vec;
          end
        end else if (boundary && soft_redir) begin
          redirect_d = 1'b1;
        end
      end
      epd_pkg::EPD_ST_DFLT: begin
        if (vchk.beyond) begin
          state_d    = epd_pkg::EPD_ST_SHUT;
          shutdown_d = 1'b1;
        end else begin
          state_d       = epd_pkg::EPD_ST_RUN;
          deliver_d     = 1'b1;
          deliver_vec_d = epd_pkg::EPD_VEC_DBL;
        end
      end
      epd_pkg::EPD_ST_SHUT: begin
        // Only reset leaves this state
        state_d = epd_pkg::EPD_ST_SHUT;
      end
      default: begin
        state_d = epd_pkg::EPD_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q       <= epd_pkg::EPD_ST_RUN;
      vt_limit_q    <= epd_pkg::EPD_VT_LIM_RST;
      nmi_blk_q     <= 1'b0;
      deliver_q     <= 1'b0;
      deliver_vec_q <= 8'h00;
      deliver_cat_q <= epd_pkg::EPD_CAT_NONE;
      saved_ip_q    <= epd_pkg::EPD_IP_RST;
      redirect_q    <= 1'b0;
      io_gp_q       <= 1'b0;
      shutdown_q    <= 1'b0;
    end else begin
      state_q       <= state_d;
      vt_limit_q    <= vt_limit_d;
      nmi_blk_q     <= nmi_blk_d;
      deliver_q     <= deliver_d;
      deliver_vec_q <= deliver_vec_d;
      deliver_cat_q <= deliver_cat_d;
      saved_ip_q    <= saved_ip_d;
      redirect_q    <= redirect_d;
      io_gp_q       <= io_gp_d;
      shutdown_q    <= shutdown_d;
    end
  end

  assign deliver      = deliver_q;
  assign deliver_vec  = deliver_vec_q;
  assign deliver_cat  = deliver_cat_q;
  assign saved_ip     = saved_ip_q;
  assign redirect_v86 = redirect_q;
  assign io_gp        = io_gp_q;
  assign nmi_blocked  = nmi_blk_q;
  assign shutdown     = shutdown_q;

  // Checks
  default clocking cb_core @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_trap_first;
    deliver_q && $past(trap_req && boundary && !reset &&
                       state_q == epd_pkg::EPD_ST_RUN)
      |-> deliver_cat_q == epd_pkg::EPD_CAT_TRAP;
  endproperty
  a_trap_first: assert property (p_trap_first)
    else $error("trap lost priority");

  property p_ext_boundary;
    deliver_q && deliver_cat_q == epd_pkg::EPD_CAT_EXT &&
      $past(state_q == epd_pkg::EPD_ST_RUN) |-> $past(boundary);
  endproperty
  a_ext_boundary: assert property (p_ext_boundary)
    else $error("interrupt taken off a boundary");

  property p_nmi_set;
    state_q == epd_pkg::EPD_ST_RUN && boundary && take_nmi |=> nmi_blk_q;
  endproperty
  a_nmi_set: assert property (p_nmi_set)
    else $error("nmi not masked after recognition");

  property p_nmi_hold;
    nmi_blk_q && !int_return_done |=> nmi_blk_q;
  endproperty
  a_nmi_hold: assert property (p_nmi_hold)
    else $error("nmi mask dropped without return");

  property p_df_vec;
    deliver_q && $past(state_q == epd_pkg::EPD_ST_DFLT)
      |-> deliver_vec_q == epd_pkg::EPD_VEC_DBL;
  endproperty
  a_df_vec: assert property (p_df_vec)
    else $error("double fault delivered with wrong vector");

  property p_shut_entry;
    $rose(shutdown_q) |-> $past(state_q == epd_pkg::EPD_ST_DFLT);
  endproperty
  a_shut_entry: assert property (p_shut_entry)
    else $error("shutdown without double fault");

  property p_shut_stays;
    shutdown_q |=> shutdown_q && !deliver_q && !redirect_q;
  endproperty
  a_shut_stays: assert property (p_shut_stays)
    else $error("activity during shutdown");

  property p_redir;
    redirect_q |-> $past(virtual_mode_extensions_flag && v86_mode);
  endproperty
  a_redir: assert property (p_redir)
    else $error("redirect outside virtual mode");

  property p_io_gp;
    io_gp_q |-> $past(io_req);
  endproperty
  a_io_gp: assert property (p_io_gp)
    else $error("protection fault without lookup");
endmodule
`default_nettype wire

// *** verification/epd_src.sv ***
// Purpose: Pipeline side, marks boundaries, sets I/O map base
// Assumes: One boundary every fourth clock
// Notes:   Base sits just past the reset segment limit, so lookups fault until the limit is raised
`timescale 1ns/1ps
`default_nettype none
module epd_src (
  // Pipeline
  input  wire logic   clk,
  output logic        boundary,
  output logic [31:0] io_map_base
);
  logic [1:0] cnt_q = 2'h0;
  always @(negedge clk) cnt_q <= cnt_q + 2'h1;
  assign boundary    = (cnt_q == 2'h3);
  assign io_map_base = 32'h0000_0068;
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the exception priority unit
// Assumes: Outcomes show within eight clocks
// Notes:   Shutdown runs last, only reset leaves it
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, reset = 1'b1, boundary, int_return_done, nmi_req;
  logic intr_req;
  logic intr_enable, load_vector_table_descriptor, v86_mode, soft_int;
  logic virtual_mode_extensions_flag, trap_req, fetch_flt, dec_flt;
  logic exec_flt, io_req, deliver, redirect_v86, io_gp, nmi_blocked;
  logic shutdown;
  logic [7:0] trap_vec, fetch_vec, dec_vec, exec_vec, intr_vec, soft_vec;
  logic [7:0] deliver_vec;
  logic [2:0] deliver_cat;
  logic [15:0] vt_limit_in, io_port;
  logic [31:0] ip_boundary, io_map_base, tseg_limit, saved_ip;
  logic [255:0] redir_bitmap;
  int n_mismatch = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  epd_src src (.clk(clk), .boundary(boundary), .io_map_base(io_map_base));
  epd_core dut (.*);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_on(ref logic s);
    int i;
    for (i = 0; i < 8 && s !== 1'b1; i++) @(negedge clk);
    if (s !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic take(logic [2:0] c, logic [7:0] v);
    wait_on(deliver);
    chk("deliver_cat", {29'h0, c}, {29'h0, deliver_cat});
    chk("deliver_vec", {24'h0, v}, {24'h0, deliver_vec});
    @(negedge clk);
  endtask
  task automatic quiet(string nm);
    int i, hits;
    hits = 0;
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      if (deliver === 1'b1) hits++;
    end
    chk(nm, 32'h0, hits);
  endtask
  task automatic load_limit(logic [15:0] lim);
    vt_limit_in = lim;
    load_vector_table_descriptor = 1'b1;
    @(negedge clk);
    load_vector_table_descriptor = 1'b0;
  endtask
  task automatic t_io();
    io_req = 1'b1;
    repeat (2) @(negedge clk);
    chk("io_gp", 32'h1, {31'h0, io_gp});
    tseg_limit = 32'h0000_0068;
    repeat (2) @(negedge clk);
    chk("io_gp_in", 32'h0, {31'h0, io_gp});
    {io_port, tseg_limit} = {16'hFFFF, 32'h0001_0066};
    repeat (2) @(negedge clk);
    chk("io_gp_nowrap", 32'h1, {31'h0, io_gp});
    {io_req, io_port} = '0;
    tseg_limit = epd_pkg::EPD_TSEG_LIM_RST;
    @(negedge clk);
  endtask
  task automatic t_prio();
    {intr_vec, fetch_vec, dec_vec} = {8'h20, 8'h0E, 8'h06};
    ip_boundary = 32'h0000_1234;
    {trap_req, intr_req, intr_enable, fetch_flt, exec_flt} = 5'h1F;
    take(epd_pkg::EPD_CAT_TRAP, 8'h00);
    {trap_req, dec_flt, ip_boundary} = {2'b01, 32'h0000_5678};
    take(epd_pkg::EPD_CAT_EXT, 8'h20);
    chk("saved_ip", 32'h0000_5678, saved_ip);
    intr_req = 1'b0;
    take(epd_pkg::EPD_CAT_FETCH, 8'h0E);
    fetch_flt = 1'b0;
    take(epd_pkg::EPD_CAT_DEC, 8'h06);
    dec_flt = 1'b0;
    take(epd_pkg::EPD_CAT_EXEC, 8'h00);
    exec_flt = 1'b0;
  endtask
  task automatic t_nmi();
    nmi_req = 1'b1;
    take(epd_pkg::EPD_CAT_EXT, epd_pkg::EPD_VEC_NMI);
    chk("nmi_blocked", 32'h1, {31'h0, nmi_blocked});
    quiet("nmi_masked");
    int_return_done = 1'b1;
    @(negedge clk);
    int_return_done = 1'b0;
    take(epd_pkg::EPD_CAT_EXT, epd_pkg::EPD_VEC_NMI);
    nmi_req = 1'b0;
    int_return_done = 1'b1;
    @(negedge clk);
    int_return_done = 1'b0;
    @(negedge clk);
    chk("nmi_unblocked", 32'h0, {31'h0, nmi_blocked});
  endtask
  task automatic t_redir();
    {v86_mode, virtual_mode_extensions_flag, soft_vec} = {2'b11, 8'h21};
    soft_int = 1'b1;
    wait_on(redirect_v86);
    chk("redirect", 32'h1, {31'h0, redirect_v86});
    virtual_mode_extensions_flag = 1'b0;
    @(negedge clk);
    take(epd_pkg::EPD_CAT_EXEC, 8'h21);
    chk("redirect_off", 32'h0, {31'h0, redirect_v86});
    {soft_int, v86_mode} = 2'b00;
    @(negedge clk);
  endtask
  task automatic t_dflt();
    load_limit(16'h0047);
    {exec_flt, exec_vec} = {1'b1, epd_pkg::EPD_VEC_PROT};
    take(epd_pkg::EPD_CAT_EXEC, epd_pkg::EPD_VEC_DBL);
    exec_flt = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_shut();
    load_limit(16'h0007);
    {exec_flt, exec_vec} = {1'b1, epd_pkg::EPD_VEC_PROT};
    wait_on(shutdown);
    chk("shutdown", 32'h1, {31'h0, shutdown});
    quiet("shut_quiet");
    exec_flt = 1'b0;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk("shutdown_reset", 32'h0, {31'h0, shutdown});
    exec_flt = 1'b1;
    take(epd_pkg::EPD_CAT_EXEC, epd_pkg::EPD_VEC_PROT);
    exec_flt = 1'b0;
  endtask
  initial begin
    {int_return_done, nmi_req, intr_req, intr_enable, v86_mode} = '0;
    {load_vector_table_descriptor, virtual_mode_extensions_flag} = '0;
    {trap_req, fetch_flt, dec_flt, exec_flt, io_req, io_port} = '0;
    {trap_vec, fetch_vec, dec_vec, exec_vec, intr_vec, soft_vec} = '0;
    {vt_limit_in, ip_boundary, redir_bitmap, soft_int} = '0;
    tseg_limit = epd_pkg::EPD_TSEG_LIM_RST;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    t_io();
    t_prio();
    t_nmi();
    t_redir();
    t_dflt();
    t_shut();
    end_of_test();
  end
endmodule
`default_nettype wire
